// file: rtl/ppo_port_top.sv
// Operation
// R01: jtag enabled takes four port f pins away from port register control
// R02: test data out carries serial bits from instruction or selected data register
// R03: test data out is driven only in the instruction or data shift states
// R04: outside shift states test data out is undriven with its pull-up on
// R05: test mode select steers the tap state machine
// R06: all tap activity is timed by the test clock input
// R07: port f bits 3 to 0 keep plain port function, no digital overrides
// R08: port g bit 5 is input only with pull-up always on, reset input
// R09: reset disable fuse at zero turns port g bit 5 into plain input
// R10: port g bit 4 feeds timer/counter 0 external clock
// R11: port g bit 3 feeds timer/counter 1 external clock
// R12: global pull-up disable bit turns off every port pull-up; code leaves port g bit 5 and the port f test pin pull-ups on
// R13: with jtag enabled, tdi, tms and tck pull-ups stay on, even in reset
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module ppo_port_top (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [5:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [7:0] rd_data_o,
   // fuses
   input wire logic test_port_enabled_i,
   input wire logic reset_pin_disable_fuse_i,
   // port a pins
   input wire logic [7:0] pa_in_i,
   output logic [7:0] pa_out_o,
   output logic [7:0] pa_oe_n_o,
   output logic [7:0] pa_pullup_o,
   // port b pins
   input wire logic [7:0] pb_in_i,
   output logic [7:0] pb_out_o,
   output logic [7:0] pb_oe_n_o,
   output logic [7:0] pb_pullup_o,
   // port f pins and its outside register bits
   input wire logic [7:0] pf_in_i,
   input wire logic [7:0] pf_dir_i,
   input wire logic [7:0] pf_latch_i,
   output logic [7:0] pf_out_o,
   output logic [7:0] pf_oe_n_o,
   output logic [7:0] pf_pullup_o,
   output logic [7:0] pf_din_o,
   // port g pins and its outside register bits
   input wire logic [5:0] pg_in_i,
   input wire logic [4:0] pg_dir_i,
   input wire logic [4:0] pg_latch_i,
   output logic [5:0] pg_out_o,
   output logic [5:0] pg_oe_n_o,
   output logic [5:0] pg_pullup_o,
   output logic [5:0] pg_din_o,
   // alternate function outputs
   output logic pg_reset_n_o,
   output logic counter0_ext_clock_in_o,
   output logic counter1_ext_clock_in_o
);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] pa_dir_r;
   logic [7:0] pa_latch_r;
   logic [7:0] pb_dir_r;
   logic [7:0] pb_latch_r;
   logic [7:0] micro_ctrl_r;
   logic [7:0] pa_sync_r;
   logic [7:0] pb_sync_r;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic pullup_global_disable;
   logic test_port_on;

   assign pullup_global_disable = micro_ctrl_r[ppo_pkg::MC_PULLUP_GLOBAL_DISABLE_BIT];
   assign test_port_on = test_port_enabled_i
                         & ~micro_ctrl_r[ppo_pkg::MC_TEST_PORT_DISABLE_BIT];

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pa_dir_r <= ppo_pkg::RST_DIR;
         pa_latch_r <= ppo_pkg::RST_LATCH;
         pb_dir_r <= ppo_pkg::RST_DIR;
         pb_latch_r <= ppo_pkg::RST_LATCH;
         micro_ctrl_r <= ppo_pkg::RST_MICRO_CTRL;
      end else if (wr_en_i) begin
         case (addr_i)
            ppo_pkg::OFF_PA_IN: pa_latch_r <= pa_latch_r ^ wr_data_i;
            ppo_pkg::OFF_PA_DIR: pa_dir_r <= wr_data_i;
            ppo_pkg::OFF_PA_LATCH: pa_latch_r <= wr_data_i;
            ppo_pkg::OFF_PB_IN: pb_latch_r <= pb_latch_r ^ wr_data_i;
            ppo_pkg::OFF_PB_DIR: pb_dir_r <= wr_data_i;
            ppo_pkg::OFF_PB_LATCH: pb_latch_r <= wr_data_i;
            ppo_pkg::OFF_MICRO_CTRL: micro_ctrl_r <= wr_data_i & ppo_pkg::MICRO_CTRL_WR_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pa_sync_r <= 8'h00;
         pb_sync_r <= 8'h00;
      end else begin
         pa_sync_r <= pa_in_i;
         pb_sync_r <= pb_in_i;
      end
   end

   always_comb begin
      rd_data_nxt = ppo_pkg::RD_UNMAPPED;
      case (addr_i)
         ppo_pkg::OFF_PA_IN: rd_data_nxt = pa_sync_r;
         ppo_pkg::OFF_PA_DIR: rd_data_nxt = pa_dir_r;
         ppo_pkg::OFF_PA_LATCH: rd_data_nxt = pa_latch_r;
         ppo_pkg::OFF_PB_IN: rd_data_nxt = pb_sync_r;
         ppo_pkg::OFF_PB_DIR: rd_data_nxt = pb_dir_r;
         ppo_pkg::OFF_PB_LATCH: rd_data_nxt = pb_latch_r;
         ppo_pkg::OFF_MICRO_CTRL: rd_data_nxt = micro_ctrl_r;
         default: rd_data_nxt = ppo_pkg::RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rd_data_r <= 8'h00;
      end else if (rd_en_i) begin
         rd_data_r <= rd_data_nxt;
      end else begin
         rd_data_r <= 8'h00;
      end
   end
   assign rd_data_o = rd_data_r;

   // ****************************************
   // test clock sampling
   // ****************************************
   logic tck_q_r;
   logic tck_prev_r;
   logic tms_q_r;
   logic tdi_q_r;
   logic tck_rise;
   logic tck_fall;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         tck_q_r <= 1'b0;
         tck_prev_r <= 1'b0;
         tms_q_r <= 1'b1;
         tdi_q_r <= 1'b1;
      end else begin
         tck_q_r <= pf_in_i[ppo_pkg::PF_TCK_BIT];
         tck_prev_r <= tck_q_r;
         tms_q_r <= pf_in_i[ppo_pkg::PF_TMS_BIT];
         tdi_q_r <= pf_in_i[ppo_pkg::PF_TDI_BIT];
      end
   end

   assign tck_rise = tck_q_r & ~tck_prev_r; // [R06]
   assign tck_fall = ~tck_q_r & tck_prev_r; // [R06]

   // ****************************************
   // tap state machine
   // ****************************************
   ppo_pkg::ppo_tap_e tap_st_r;
   ppo_pkg::ppo_tap_e tap_st_nxt;
   logic shift_st;

   always_comb begin
      tap_st_nxt = tap_st_r;
      case (tap_st_r) // [R05]
         ppo_pkg::TAP_RESET: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_RESET : ppo_pkg::TAP_IDLE;
         ppo_pkg::TAP_IDLE: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_SEL_DR : ppo_pkg::TAP_IDLE;
         ppo_pkg::TAP_SEL_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_SEL_IR : ppo_pkg::TAP_CAP_DR;
         ppo_pkg::TAP_CAP_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_EXIT1_DR : ppo_pkg::TAP_SHIFT_DR;
         ppo_pkg::TAP_SHIFT_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_EXIT1_DR : ppo_pkg::TAP_SHIFT_DR;
         ppo_pkg::TAP_EXIT1_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_UPD_DR : ppo_pkg::TAP_PAUSE_DR;
         ppo_pkg::TAP_PAUSE_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_EXIT2_DR : ppo_pkg::TAP_PAUSE_DR;
         ppo_pkg::TAP_EXIT2_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_UPD_DR : ppo_pkg::TAP_SHIFT_DR;
         ppo_pkg::TAP_UPD_DR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_SEL_DR : ppo_pkg::TAP_IDLE;
         ppo_pkg::TAP_SEL_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_RESET : ppo_pkg::TAP_CAP_IR;
         ppo_pkg::TAP_CAP_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_EXIT1_IR : ppo_pkg::TAP_SHIFT_IR;
         ppo_pkg::TAP_SHIFT_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_EXIT1_IR : ppo_pkg::TAP_SHIFT_IR;
         ppo_pkg::TAP_EXIT1_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_UPD_IR : ppo_pkg::TAP_PAUSE_IR;
         ppo_pkg::TAP_PAUSE_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_EXIT2_IR : ppo_pkg::TAP_PAUSE_IR;
         ppo_pkg::TAP_EXIT2_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_UPD_IR : ppo_pkg::TAP_SHIFT_IR;
         ppo_pkg::TAP_UPD_IR: tap_st_nxt = tms_q_r ? ppo_pkg::TAP_SEL_DR : ppo_pkg::TAP_IDLE;
         default: tap_st_nxt = ppo_pkg::TAP_RESET;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || !test_port_on) begin
         tap_st_r <= ppo_pkg::TAP_RESET;
      end else if (tck_rise) begin
         tap_st_r <= tap_st_nxt; // [R05] [R06]
      end
   end
   assign shift_st = (tap_st_r == ppo_pkg::TAP_SHIFT_IR) || (tap_st_r == ppo_pkg::TAP_SHIFT_DR);

   // ****************************************
   // scan registers and test data out
   // ****************************************
   logic [3:0] ir_sh_r;
   logic [3:0] ir_r;
   logic [7:0] scan_sh_r;
   logic bypass_r;
   logic tdo_r;
   logic ir_lsb;

   assign ir_lsb = ir_sh_r[0];

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || !test_port_on) begin
         ir_sh_r <= ppo_pkg::IR_CAPTURE;
         ir_r <= ppo_pkg::IR_BYPASS;
      end else if (tck_rise) begin
         case (tap_st_r)
            ppo_pkg::TAP_RESET: ir_r <= ppo_pkg::IR_BYPASS;
            ppo_pkg::TAP_CAP_IR: ir_sh_r <= ppo_pkg::IR_CAPTURE;
            ppo_pkg::TAP_SHIFT_IR: ir_sh_r <= {tdi_q_r, ir_sh_r[3:1]};
            ppo_pkg::TAP_UPD_IR: ir_r <= ir_sh_r;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || !test_port_on) begin
         scan_sh_r <= 8'h00;
         bypass_r <= 1'b0;
      end else if (tck_rise) begin
         case (tap_st_r)
            ppo_pkg::TAP_CAP_DR: begin
               scan_sh_r <= pf_in_i;
               bypass_r <= 1'b0;
            end
            ppo_pkg::TAP_SHIFT_DR: begin
               if (ir_r == ppo_pkg::IR_SAMPLE_PINS) begin
                  scan_sh_r <= {tdi_q_r, scan_sh_r[7:1]};
               end else begin
                  bypass_r <= tdi_q_r;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || !test_port_on) begin
         tdo_r <= 1'b1;
      end else if (tck_fall) begin
         if (tap_st_r == ppo_pkg::TAP_SHIFT_IR) begin
            tdo_r <= ir_lsb; // [R02]
         end else if (ir_r == ppo_pkg::IR_SAMPLE_PINS) begin
            tdo_r <= scan_sh_r[0]; // [R02]
         end else begin
            tdo_r <= bypass_r; // [R02]
         end
      end
   end

   // ****************************************
   // pin control
   // ****************************************
   logic [7:0] pull_keep;
   logic [7:0] pf_out_nxt;
   logic [7:0] pf_oe_n_nxt;
   logic [7:0] pf_pull_nxt;
   logic [7:0] pf_dien_nxt;
   logic [5:0] pg_pull_nxt;

   assign pull_keep = {8{~pullup_global_disable}};

   always_comb begin
      pf_out_nxt = pf_latch_i; // [R07]
      pf_oe_n_nxt = ~pf_dir_i; // [R07]
      pf_pull_nxt = ~pf_dir_i & pf_latch_i & pull_keep; // [R12]
      pf_dien_nxt = 8'hFF;
      if (test_port_on) begin
         pf_out_nxt = pf_latch_i & ~ppo_pkg::PF_TEST_MASK; // [R01]
         pf_out_nxt[ppo_pkg::PF_TDO_BIT] = tdo_r; // [R02]
         pf_oe_n_nxt = ~pf_dir_i | ppo_pkg::PF_TEST_IN_MASK; // [R01]
         pf_oe_n_nxt[ppo_pkg::PF_TDO_BIT] = ~shift_st; // [R03] [R04]
         pf_pull_nxt = pf_pull_nxt | ppo_pkg::PF_TEST_MASK; // [R04] [R13]
         pf_dien_nxt = ppo_pkg::PF_TEST_DIEN; // [R01]
      end
      pg_pull_nxt = {1'b1, ~pg_dir_i & pg_latch_i & pull_keep[4:0]}; // [R08] [R12]
   end

   always_ff @(posedge core_clk_i) begin
      pa_out_o <= pa_latch_r;
      pa_oe_n_o <= ~pa_dir_r;
      pa_pullup_o <= ~pa_dir_r & pa_latch_r & pull_keep; // [R12]
      pb_out_o <= pb_latch_r;
      pb_oe_n_o <= ~pb_dir_r;
      pb_pullup_o <= ~pb_dir_r & pb_latch_r & pull_keep; // [R12]
   end

   always_ff @(posedge core_clk_i) begin
      pf_out_o <= pf_out_nxt;
      pf_oe_n_o <= pf_oe_n_nxt;
      pf_pullup_o <= pf_pull_nxt; // [R13]
      pf_din_o <= pf_in_i & pf_dien_nxt;
   end

   always_ff @(posedge core_clk_i) begin
      pg_out_o <= {1'b0, pg_latch_i};
      pg_oe_n_o <= {1'b1, ~pg_dir_i}; // [R08]
      pg_pullup_o <= pg_pull_nxt;
      pg_din_o <= pg_in_i;
      pg_reset_n_o <= reset_pin_disable_fuse_i ? pg_in_i[ppo_pkg::PG_RESET_BIT] : 1'b1; // [R09]
      counter0_ext_clock_in_o <= pg_in_i[ppo_pkg::PG_CNT0_CLK_BIT]; // [R10]
      counter1_ext_clock_in_o <= pg_in_i[ppo_pkg::PG_CNT1_CLK_BIT]; // [R11]
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_tdo_drive_shift: assert property ( // [R03]
      $past(test_port_on) && $past(shift_st) |-> !pf_oe_n_o[6] && pf_out_o[6] == $past(tdo_r))
      else $error("tdo not driven with its data in a shift state");
   a_tdo_idle_pull: assert property ( // [R04]
      $past(test_port_on) && !$past(shift_st) |-> pf_oe_n_o[6] && pf_pullup_o[6])
      else $error("tdo driven or not pulled up outside shift");
   a_tdo_ir_source: assert property ( // [R02]
      tck_fall && tap_st_r == ppo_pkg::TAP_SHIFT_IR && test_port_on |=> tdo_r == $past(ir_lsb))
      else $error("tdo does not follow instruction register");
   a_test_pins_free: assert property ( // [R01]
      $past(test_port_on) |-> pf_oe_n_o[7] && pf_oe_n_o[5] && pf_oe_n_o[4]
                              && pf_din_o[7:5] == 3'b000)
      else $error("test pins still under port control");
   a_test_pullups: assert property ( // [R13]
      $past(test_port_on) |-> pf_pullup_o[7] && pf_pullup_o[5] && pf_pullup_o[4])
      else $error("test pin pull-up off");
   a_tap_tms_walk: assert property ( // [R05]
      test_port_on && tck_rise && tap_st_r == ppo_pkg::TAP_IDLE && tms_q_r
      |=> tap_st_r == ppo_pkg::TAP_SEL_DR)
      else $error("tap did not follow tms");
   a_tap_needs_tck: assert property ( // [R06]
      test_port_on && !tck_rise |=> $stable(tap_st_r))
      else $error("tap moved without test clock");
   a_adc_plain: assert property ( // [R07]
      pf_oe_n_o[3:0] == ~$past(pf_dir_i[3:0]) && pf_out_o[3:0] == $past(pf_latch_i[3:0]))
      else $error("port f low bits overridden");
   a_reset_pin_input: assert property ( // [R08]
      pg_oe_n_o[5] && pg_pullup_o[5] && !pg_out_o[5])
      else $error("reset pin not an input with pull-up");
   a_reset_fuse_mode: assert property ( // [R09]
      !$past(reset_pin_disable_fuse_i) |-> pg_reset_n_o && pg_din_o[5] == $past(pg_in_i[5]))
      else $error("fused reset pin still resets");
   a_counter0_clock: assert property ( // [R10]
      counter0_ext_clock_in_o == $past(pg_in_i[4]))
      else $error("counter 0 clock not from port g bit 4");
   a_counter1_clock: assert property ( // [R11]
      counter1_ext_clock_in_o == $past(pg_in_i[3]))
      else $error("counter 1 clock not from port g bit 3");
   a_pullup_global_off: assert property ( // [R12]
      $past(pullup_global_disable) |-> pa_pullup_o == 8'h00 && pb_pullup_o == 8'h00
                                       && pg_pullup_o[4:0] == 5'h00)
      else $error("pull-up on while globally disabled");

   c_shift_dr: cover property (tap_st_r == ppo_pkg::TAP_SHIFT_DR && tck_rise);
   c_shift_ir: cover property (tap_st_r == ppo_pkg::TAP_SHIFT_IR && tck_fall);
   c_pullup_off: cover property (pullup_global_disable && pa_latch_r != 8'h00);
   c_fuse_gpio: cover property (!reset_pin_disable_fuse_i && !pg_in_i[5]);

endmodule

// file: rtl/ppo_pkg.sv
// ****************************************
// register map and field layout
// ****************************************
package ppo_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam logic [5:0] OFF_PA_IN = 6'h00;
   localparam logic [5:0] OFF_PA_DIR = 6'h01;
   localparam logic [5:0] OFF_PA_LATCH = 6'h02;
   localparam logic [5:0] OFF_PB_IN = 6'h03;
   localparam logic [5:0] OFF_PB_DIR = 6'h04;
   localparam logic [5:0] OFF_PB_LATCH = 6'h05;
   localparam logic [5:0] OFF_MICRO_CTRL = 6'h35;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_MICRO_CTRL = 8'h00;
   localparam logic [7:0] MICRO_CTRL_WR_MASK = 8'h93;
   localparam int unsigned MC_TEST_PORT_DISABLE_BIT = 7;
   localparam int unsigned MC_PULLUP_GLOBAL_DISABLE_BIT = 4;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // ****************************************
   // port f and port g pin positions
   // ****************************************
   localparam int unsigned PF_TDI_BIT = 7;
   localparam int unsigned PF_TDO_BIT = 6;
   localparam int unsigned PF_TMS_BIT = 5;
   localparam int unsigned PF_TCK_BIT = 4;
   localparam logic [7:0] PF_TEST_MASK = 8'hF0;
   localparam logic [7:0] PF_TEST_IN_MASK = 8'hB0;
   localparam logic [7:0] PF_TEST_DIEN = 8'h1F;
   localparam int unsigned PG_RESET_BIT = 5;
   localparam int unsigned PG_CNT0_CLK_BIT = 4;
   localparam int unsigned PG_CNT1_CLK_BIT = 3;

   // ****************************************
   // test access port
   // ****************************************
   localparam int unsigned IR_W = 4;
   localparam int unsigned SCAN_W = 8;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_SAMPLE_PINS = 4'h2;

   typedef enum logic [3:0] {
      TAP_RESET = 4'b0000,
      TAP_IDLE = 4'b0001,
      TAP_SEL_DR = 4'b0010,
      TAP_CAP_DR = 4'b0011,
      TAP_SHIFT_DR = 4'b0100,
      TAP_EXIT1_DR = 4'b0101,
      TAP_PAUSE_DR = 4'b0110,
      TAP_EXIT2_DR = 4'b0111,
      TAP_UPD_DR = 4'b1000,
      TAP_SEL_IR = 4'b1001,
      TAP_CAP_IR = 4'b1010,
      TAP_SHIFT_IR = 4'b1011,
      TAP_EXIT1_IR = 4'b1100,
      TAP_PAUSE_IR = 4'b1101,
      TAP_EXIT2_IR = 4'b1110,
      TAP_UPD_IR = 4'b1111
   } ppo_tap_e;
endpackage

// file: sim/ppo_jtag_tester.sv
`timescale 1ns/1ps
// ****************************************
// boundary-scan tester on the port f pins
// ****************************************
module ppo_jtag_tester (
   // core clock for pacing
   input wire logic core_clk_i,
   // test pins
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b0;
      tdi_o = 1'b0;
   end

   // select and data set up well before the rise
   task automatic present(input logic tms_v, input logic tdi_v);
      @(posedge core_clk_i);
      tms_o <= tms_v;
      tdi_o <= tdi_v;
      repeat (4) @(posedge core_clk_i);
   endtask

   // one test clock pulse, low between pulses
   task automatic pulse();
      @(posedge core_clk_i);
      tck_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      tck_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
   endtask
endmodule

// file: sim/port_pin_override_and_regs_test.sv
`timescale 1ns/1ps
module port_pin_override_and_regs_test;
   logic core_clk, nrst, we, re, test_en, rst_fuse;
   logic [5:0] addr;
   logic [7:0] wdat, pa_in, pb_in, pf_dir, pf_latch;
   logic [3:0] pf_lo;
   logic [5:0] pg_in;
   logic [4:0] pg_dir, pg_latch;
   logic [7:0] rd_data, pa_out, pa_oe_n, pa_pu, pb_out, pb_oe_n, pb_pu;
   logic [7:0] pf_out, pf_oe_n, pf_pu, pf_din;
   logic [5:0] pg_out, pg_oe_n, pg_pu, pg_din;
   logic pg_rst_n, cnt0_clk, cnt1_clk, jt_tck, jt_tms, jt_tdi, rd_pend = 1'b0, sh, tx, pu_off, on;
   wire logic tdo_pin;
   wire logic [7:0] pf_in;
   logic [7:0] rd_q[$];
   logic [7:0] da, la, db, lb, mc, tg, pu_f;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;

   // undriven test data out reads the pull-up, else flips
   assign tdo_pin = !pf_oe_n[6] ? pf_out[6] : (pf_pu[6] ? 1'b1 : ~pf_out[6]);
   assign pf_in = {jt_tdi, tdo_pin, jt_tms, jt_tck, pf_lo};

   ppo_port_top dut (
      .core_clk_i(core_clk), .nrst_i(nrst),
      .addr_i(addr), .wr_data_i(wdat), .wr_en_i(we), .rd_en_i(re), .rd_data_o(rd_data),
      .test_port_enabled_i(test_en), .reset_pin_disable_fuse_i(rst_fuse),
      .pa_in_i(pa_in), .pa_out_o(pa_out), .pa_oe_n_o(pa_oe_n), .pa_pullup_o(pa_pu),
      .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_n_o(pb_oe_n), .pb_pullup_o(pb_pu),
      .pf_in_i(pf_in), .pf_dir_i(pf_dir), .pf_latch_i(pf_latch), .pf_out_o(pf_out),
      .pf_oe_n_o(pf_oe_n), .pf_pullup_o(pf_pu), .pf_din_o(pf_din),
      .pg_in_i(pg_in), .pg_dir_i(pg_dir), .pg_latch_i(pg_latch), .pg_out_o(pg_out),
      .pg_oe_n_o(pg_oe_n), .pg_pullup_o(pg_pu), .pg_din_o(pg_din),
      .pg_reset_n_o(pg_rst_n), .counter0_ext_clock_in_o(cnt0_clk),
      .counter1_ext_clock_in_o(cnt1_clk)
   );

   ppo_jtag_tester jt (.core_clk_i(core_clk), .tck_o(jt_tck), .tms_o(jt_tms), .tdi_o(jt_tdi));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ****************************************
   // compare, report, close
   // ****************************************
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         $display("unexpected timeout expected done seen running");
         close_out();
      end
   end

   // read data stands the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_pend) begin
         chk("rd_data_o", rd_data, rd_q.pop_front());
      end
      rd_pend = re;
   end

   // ****************************************
   // register bus
   // ****************************************
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      we <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge core_clk);
      we <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      re <= 1'b1;
      addr <= a;
      rd_q.push_back(exp);
      @(posedge core_clk);
      re <= 1'b0;
   endtask

   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   localparam logic [17:0] TMS_SEQ = 18'h1_8706;
   localparam logic [17:0] TDI_SEQ = 18'h0_a1e0;
   localparam logic [17:0] SHIFT_AT = 18'h0_e1e0;
   localparam logic [17:0] TDO_EXP = 18'h0_4020;
   localparam logic [17:0] TDI_SAMPLE = 18'h0_0040;
   localparam logic [17:0] TDO_SAMPLE = 18'h0_c020;

   initial begin
      nrst = 1'b0;
      we = 1'b0;
      re = 1'b0;
      addr = 6'h00;
      wdat = 8'h00;
      test_en = 1'b1;
      rst_fuse = 1'b1;
      pa_in = 8'h00;
      pb_in = 8'h00;
      pf_lo = 4'h6;
      pf_dir = 8'hff;
      pf_latch = 8'hff;
      pg_in = 6'h00;
      pg_dir = 5'h00;
      pg_latch = 5'h00;
      void'($urandom(32'h93ac5ec3));
      repeat (4) @(posedge core_clk);
      #1;
      chk("pf_pullup_o", pf_pu & 8'hf0, 8'hf0);
      chk("pf_oe_n_o", pf_oe_n & 8'hb0, 8'hb0);
      @(posedge core_clk);
      nrst <= 1'b1;
      rd(ppo_pkg::OFF_PA_DIR, ppo_pkg::RST_DIR);
      rd(ppo_pkg::OFF_PA_LATCH, ppo_pkg::RST_LATCH);
      rd(ppo_pkg::OFF_PB_DIR, ppo_pkg::RST_DIR);
      rd(ppo_pkg::OFF_PB_LATCH, ppo_pkg::RST_LATCH);
      rd(ppo_pkg::OFF_MICRO_CTRL, ppo_pkg::RST_MICRO_CTRL);
      rd(6'h3f, ppo_pkg::RD_UNMAPPED);
      // bypass pass, then a pass scanning the pins with the sample instruction
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 18; k++) begin
            jt.present(TMS_SEQ[k], (p == 0) ? TDI_SEQ[k] : TDI_SAMPLE[k]);
            #1;
            sh = SHIFT_AT[k];
            tx = (p == 0) ? TDO_EXP[k] : TDO_SAMPLE[k];
            chk("pf_oe_n_o", pf_oe_n & 8'hf0, {1'b1, !sh, 2'b11, 4'h0});
            chk("pf_pullup_o", pf_pu & 8'hf0, 8'hf0);
            chk("pf_din_o", pf_din & 8'he0, 8'h00);
            if (sh) begin
               chk("tdo pin", {7'h00, tdo_pin}, {7'h00, tx});
            end else begin
               chk("tdo pin", {7'h00, tdo_pin}, 8'h01);
            end
            jt.pulse();
         end
      end
      // random pin and register settings
      for (int i = 0; i < 24; i++) begin
         da = 8'($urandom());
         la = 8'($urandom());
         db = 8'($urandom());
         lb = 8'($urandom());
         mc = 8'($urandom());
         tg = 8'($urandom());
         @(posedge core_clk);
         pa_in <= 8'($urandom());
         pb_in <= 8'($urandom());
         pf_lo <= 4'($urandom());
         pf_dir <= 8'($urandom());
         pf_latch <= 8'($urandom());
         pg_in <= 6'($urandom());
         pg_dir <= 5'($urandom());
         pg_latch <= 5'($urandom());
         rst_fuse <= 1'($urandom());
         test_en <= 1'($urandom());
         wr(ppo_pkg::OFF_PA_DIR, da);
         wr(ppo_pkg::OFF_PA_LATCH, la);
         wr(ppo_pkg::OFF_PB_DIR, db);
         wr(ppo_pkg::OFF_PB_LATCH, lb);
         wr(ppo_pkg::OFF_PB_IN, tg);
         wr(ppo_pkg::OFF_MICRO_CTRL, mc);
         lb = lb ^ tg;
         rd(ppo_pkg::OFF_PA_DIR, da);
         rd(ppo_pkg::OFF_PB_LATCH, lb);
         rd(ppo_pkg::OFF_MICRO_CTRL, mc & ppo_pkg::MICRO_CTRL_WR_MASK);
         rd(ppo_pkg::OFF_PA_IN, pa_in);
         rd(ppo_pkg::OFF_PB_IN, pb_in);
         settle();
         pu_off = mc[ppo_pkg::MC_PULLUP_GLOBAL_DISABLE_BIT];
         on = test_en & !mc[ppo_pkg::MC_TEST_PORT_DISABLE_BIT];
         pu_f = ~pf_dir & pf_latch & {8{!pu_off}};
         chk("pa_oe_n_o", pa_oe_n, ~da);
         chk("pa_out_o", pa_out, la);
         chk("pa_pullup_o", pa_pu, ~da & la & {8{!pu_off}});
         chk("pb_oe_n_o", pb_oe_n, ~db);
         chk("pb_out_o", pb_out, lb);
         chk("pb_pullup_o", pb_pu, ~db & lb & {8{!pu_off}});
         chk("pf_oe_n_o", pf_oe_n, on ? {4'hf, ~pf_dir[3:0]} : ~pf_dir);
         chk("pf_out_o", pf_out & {1'b1, !on, 6'h3f},
             on ? {4'h0, pf_latch[3:0]} : pf_latch);
         chk("pf_pullup_o", pf_pu, on ? {4'hf, pu_f[3:0]} : pu_f);
         chk("pf_din_o", pf_din, on ? {3'b000, pf_in[4:0]} : pf_in);
         chk("pg_oe_n_o", {2'b00, pg_oe_n}, {3'b001, ~pg_dir});
         chk("pg_out_o", {2'b00, pg_out}, {3'b000, pg_latch});
         chk("pg_pullup_o", {2'b00, pg_pu},
             {3'b001, ~pg_dir & pg_latch & {5{!pu_off}}});
         chk("pg_din_o", {2'b00, pg_din}, {2'b00, pg_in});
         chk("pg alt inputs", {5'h00, cnt0_clk, cnt1_clk, pg_rst_n},
             {5'h00, pg_in[4], pg_in[3], rst_fuse ? pg_in[5] : 1'b1});
      end
      repeat (3) @(posedge core_clk);
      close_out();
   end
endmodule
